/* rtl/term_regs.vh */
`ifndef TERM_REGS_VH
`define TERM_REGS_VH

`define ASC_ESC 8'h1b
`define ASC_0 8'h30
`define ASC_9 8'h39
`define ASC_UC_A 8'h41
`define ASC_UC_F 8'h46
`define ASC_LC_A 8'h61
`define ASC_LC_F 8'h66
`define HEX_ALPHA_ADJ 4'h9

`define CODE_NORMAL 8'h21
`define CODE_INV_ON 8'h22
`define CODE_INV_OFF 8'h23
`define CODE_FL_ON 8'h24
`define CODE_FL_OFF 8'h25
`define CODE_SIZE 8'h29
`define CODE_ENLARGE 8'h2a
`define CODE_CURSOR 8'h2b
`define CODE_STRING 8'h34
`define CODE_POLY 8'h37
`define CODE_CIRCLE 8'h38

`define ENL_MAX 10'h005
`define SIZE_MAX 10'h001
`define X_MAX 10'h0ff
`define Y_MAX 10'h07f
`define STR_MAX 10'h020
`define LINES_MAX 10'h028
`define RAD_MAX 10'h03f
`define SCREEN_W 9'h100
`define CHAR_W_SHIFT 3'b000
`define CHAR_H_FULL 4'b0000

`define OP_CHAR 3'h1
`define OP_MOVE 3'h2
`define OP_LINE 3'h3
`define OP_CIRCLE 3'h4

`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CURSOR 4'h8
`define REG_DISCARD 4'hc
`define CTRL_EN_BIT 0
`define CTRL_SCREEN_BIT 1
`define CTRL_ABORT_BIT 2
`define CTRL_RESET 1'b1

`endif

/* rtl/terminal_draw_command_parser.v */
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "term_regs.vh"
module terminal_draw_command_parser (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  input wire screen_shown,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire out_valid,
  input wire out_ready,
  output wire [2:0] out_op,
  output wire [7:0] out_x,
  output wire [6:0] out_y,
  output wire [7:0] out_arg,
  output wire out_inverse,
  output wire out_flash,
  output wire [2:0] out_enlarge,
  output wire out_half
);

  localparam S_IDLE = 2'd0;
  localparam S_CODE = 2'd1;
  localparam S_DIG = 2'd2;
  localparam S_STR = 2'd3;
  localparam BW = 32;

  reg [1:0] state_r;
  reg [7:0] cmd_r;
  reg [9:0] acc_r;
  reg [1:0] dig_r;
  reg [1:0] flen_r;
  reg [1:0] fld_r;
  reg hexf_r;
  reg first_r;
  reg [5:0] pts_r;
  reg [5:0] rem_r;
  reg [7:0] xt_r;
  reg [6:0] yt_r;
  reg [7:0] cur_x_r;
  reg [6:0] cur_y_r;
  reg [8:0] str_x_r;
  reg [6:0] str_y_r;
  reg inv_r;
  reg fl_r;
  reg [2:0] enl_r;
  reg half_r;
  reg en_r;
  reg [15:0] disc_r;
  reg [BW-1:0] ent_r [0:1];
  reg [1:0] cnt_r;

  wire take = rx_valid & rx_ready;
  wire wb_acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire ctrl_wr = wb_acc & wb_we_i & (wb_adr_i == `REG_CTRL) & wb_sel_i[0];
  wire disc_wr = wb_acc & wb_we_i & (wb_adr_i == `REG_DISCARD) & wb_sel_i[0];
  wire scr_chg = screen_shown | (ctrl_wr & wb_dat_i[`CTRL_SCREEN_BIT]);
  wire abort = ctrl_wr & wb_dat_i[`CTRL_ABORT_BIT];

  // digit decode: low nibble of '0'..'9' is the digit itself
  wire is_dec = (rx_data >= `ASC_0) && (rx_data <= `ASC_9);
  wire is_uc = (rx_data >= `ASC_UC_A) && (rx_data <= `ASC_UC_F);
  wire is_lc = (rx_data >= `ASC_LC_A) && (rx_data <= `ASC_LC_F);
  wire is_hex = is_dec | is_uc | is_lc;
  wire [3:0] hex_val = is_dec ? rx_data[3:0] : rx_data[3:0] + `HEX_ALPHA_ADJ;
  wire digit_ok = hexf_r ? is_hex : is_dec;
  wire last_dig = (dig_r == flen_r);
  // acc * 10 as 8x + 2x avoids a multiplier
  wire [9:0] acc_bcd = {acc_r[6:0], 3'b000} + {2'b00, acc_r[6:0], 1'b0}
                       + {6'b000000, rx_data[3:0]};
  wire [9:0] acc_hex = {acc_r[5:0], hex_val};
  wire [9:0] fin = hexf_r ? acc_hex : acc_bcd;

  reg range_ok;
  always @*
  begin
    range_ok = 1'b0;
    case (cmd_r)
      `CODE_ENLARGE: range_ok = (fin <= `ENL_MAX);
      `CODE_SIZE: range_ok = (fin <= `SIZE_MAX);
      `CODE_STRING: range_ok = (fin != 10'h000) && (fin <= `STR_MAX);
      default:
        if (hexf_r)
          range_ok = (fin != 10'h000) && (fin <= `LINES_MAX);
        else if (fld_r == 2'd0)
          range_ok = (fin <= `X_MAX);
        else if (fld_r == 2'd1)
          range_ok = (fin <= `Y_MAX);
        else
          range_ok = (fin != 10'h000) && (fin <= `RAD_MAX);
    endcase
  end

  wire field_done = (state_r == S_DIG) & digit_ok & last_dig;

  // character cell geometry for the current size and enlargement
  reg [2:0] wf;
  reg [2:0] hf;
  always @*
  begin
    wf = 3'd1;
    hf = 3'd1;
    case (enl_r)
      3'd1: hf = 3'd2;
      3'd2: wf = 3'd2;
      3'd3:
      begin
        wf = 3'd2;
        hf = 3'd2;
      end
      3'd4:
      begin
        wf = 3'd3;
        hf = 3'd3;
      end
      3'd5:
      begin
        wf = 3'd4;
        hf = 3'd4;
      end
      default:
      begin
        wf = 3'd1;
        hf = 3'd1;
      end
    endcase
  end
  wire [5:0] cw = {wf, `CHAR_W_SHIFT};
  wire [6:0] ch = half_r ? {1'b0, hf, 3'b000} : {hf, `CHAR_H_FULL};
  // a character that would run past the right edge starts the next line
  wire fits = ({1'b0, str_x_r} + {4'b0000, cw}) <= {1'b0, `SCREEN_W};
  wire [7:0] px = fits ? str_x_r[7:0] : 8'h00;
  wire [6:0] py = fits ? str_y_r : str_y_r + ch;

  reg emit;
  reg [2:0] e_op;
  reg [7:0] e_x;
  reg [6:0] e_y;
  reg [7:0] e_arg;
  always @*
  begin
    emit = 1'b0;
    e_op = `OP_CHAR;
    e_x = xt_r;
    e_y = fin[6:0];
    e_arg = 8'h00;
    if (state_r == S_STR)
    begin
      emit = take;
      e_x = px;
      e_y = py;
      e_arg = rx_data;
    end
    else if (take & field_done & range_ok & ~hexf_r)
    begin
      if (cmd_r == `CODE_POLY && fld_r == 2'd1)
      begin
        emit = 1'b1;
        e_op = first_r ? `OP_MOVE : `OP_LINE;
      end
      else if (cmd_r == `CODE_CIRCLE && fld_r == 2'd2)
      begin
        emit = 1'b1;
        e_op = `OP_CIRCLE;
        e_y = yt_r;
        e_arg = fin[7:0];
      end
    end
  end

  // every word carries the attributes in force when its byte arrived
  wire [BW-1:0] e_word = {e_op, e_x, e_y, e_arg, inv_r, fl_r, enl_r, half_r};

  // at most one word per byte, so a free slot before taking is enough
  assign rx_ready = ce & en_r & (cnt_r != 2'd2);

  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= S_IDLE;
      cmd_r <= 8'h00;
      acc_r <= 10'h000;
      dig_r <= 2'd0;
      flen_r <= 2'd0;
      fld_r <= 2'd0;
      hexf_r <= 1'b0;
      first_r <= 1'b0;
      pts_r <= 6'd0;
      rem_r <= 6'd0;
      xt_r <= 8'h00;
      yt_r <= 7'h00;
      cur_x_r <= 8'h00;
      cur_y_r <= 7'h00;
      str_x_r <= 9'h000;
      str_y_r <= 7'h00;
      inv_r <= 1'b0;
      fl_r <= 1'b0;
      enl_r <= 3'd0;
      half_r <= 1'b0;
      en_r <= `CTRL_RESET;
      disc_r <= 16'h0000;
    end
    else if (ce)
    begin
      if (ctrl_wr)
        en_r <= wb_dat_i[`CTRL_EN_BIT];
      if (disc_wr)
        disc_r <= 16'h0000;
      if (abort)
        state_r <= S_IDLE;
      else if (take)
      begin
        case (state_r)
          S_IDLE:
            if (rx_data == `ASC_ESC)
              state_r <= S_CODE;
          S_CODE:
          begin
            cmd_r <= rx_data;
            acc_r <= 10'h000;
            dig_r <= 2'd0;
            fld_r <= 2'd0;
            hexf_r <= 1'b0;
            flen_r <= 2'd2;
            state_r <= S_DIG;
            case (rx_data)
              `CODE_NORMAL:
              begin
                inv_r <= 1'b0;
                fl_r <= 1'b0;
                state_r <= S_IDLE;
              end
              `CODE_INV_ON:
              begin
                inv_r <= 1'b1;
                state_r <= S_IDLE;
              end
              `CODE_INV_OFF:
              begin
                inv_r <= 1'b0;
                state_r <= S_IDLE;
              end
              `CODE_FL_ON:
              begin
                fl_r <= 1'b1;
                state_r <= S_IDLE;
              end
              `CODE_FL_OFF:
              begin
                fl_r <= 1'b0;
                state_r <= S_IDLE;
              end
              `CODE_SIZE, `CODE_ENLARGE:
                flen_r <= 2'd0;
              `CODE_STRING, `CODE_POLY:
              begin
                hexf_r <= 1'b1;
                flen_r <= 2'd1;
              end
              `CODE_CURSOR, `CODE_CIRCLE:
                flen_r <= 2'd2;
              `ASC_ESC:
                state_r <= S_CODE;
              default:
              begin
                state_r <= S_IDLE;
                disc_r <= disc_r + 16'h0001;
              end
            endcase
          end
          S_DIG:
            if (!digit_ok || !(range_ok || !last_dig))
            begin
              // a stray escape restarts rather than being lost
              state_r <= (rx_data == `ASC_ESC) ? S_CODE : S_IDLE;
              disc_r <= disc_r + 16'h0001;
            end
            else if (!last_dig)
            begin
              acc_r <= fin;
              dig_r <= dig_r + 2'd1;
            end
            else
            begin
              acc_r <= 10'h000;
              dig_r <= 2'd0;
              fld_r <= fld_r + 2'd1;
              if (fld_r == 2'd0)
                xt_r <= fin[7:0];
              if (fld_r == 2'd1)
                yt_r <= fin[6:0];
              case (cmd_r)
                `CODE_ENLARGE:
                begin
                  enl_r <= fin[2:0];
                  state_r <= S_IDLE;
                end
                `CODE_SIZE:
                begin
                  half_r <= fin[0];
                  state_r <= S_IDLE;
                end
                `CODE_CURSOR:
                  if (fld_r == 2'd1)
                  begin
                    cur_x_r <= xt_r;
                    cur_y_r <= fin[6:0];
                    state_r <= S_IDLE;
                  end
                `CODE_STRING:
                begin
                  rem_r <= fin[5:0];
                  str_x_r <= {1'b0, cur_x_r};
                  str_y_r <= cur_y_r;
                  hexf_r <= 1'b0;
                  state_r <= S_STR;
                end
                `CODE_POLY:
                  if (hexf_r)
                  begin
                    pts_r <= fin[5:0] + 6'd1;
                    hexf_r <= 1'b0;
                    flen_r <= 2'd2;
                    first_r <= 1'b1;
                    fld_r <= 2'd0;
                  end
                  else if (fld_r == 2'd1)
                  begin
                    first_r <= 1'b0;
                    pts_r <= pts_r - 6'd1;
                    fld_r <= 2'd0;
                    if (pts_r == 6'd1)
                      state_r <= S_IDLE;
                  end
                default:
                  if (fld_r == 2'd2)
                    state_r <= S_IDLE;
              endcase
            end
          default:
          begin
            str_x_r <= {1'b0, px} + {3'b000, cw};
            str_y_r <= py;
            rem_r <= rem_r - 6'd1;
            if (rem_r == 6'd1)
              state_r <= S_IDLE;
          end
        endcase
      end
      if (scr_chg)
      begin
        inv_r <= 1'b0;
        fl_r <= 1'b0;
        enl_r <= 3'd0;
        half_r <= 1'b0;
      end
    end
  end

  // two-entry buffer: entry 0 drives the outputs straight from flops
  wire pop = (cnt_r != 2'd0) & out_ready;
  wire push = emit;
  always @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_r <= 2'd0;
      ent_r[0] <= {BW{1'b0}};
      ent_r[1] <= {BW{1'b0}};
    end
    else if (ce)
    begin
      if (push && (cnt_r == 2'd0 || (cnt_r == 2'd1 && pop)))
        ent_r[0] <= e_word;
      else if (pop && cnt_r == 2'd2)
        ent_r[0] <= ent_r[1];
      if (push && cnt_r == 2'd1 && !pop)
        ent_r[1] <= e_word;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  assign out_valid = ce & (cnt_r != 2'd0);
  assign {out_op, out_x, out_y, out_arg, out_inverse, out_flash,
          out_enlarge, out_half} = ent_r[0];

  always @(posedge mclk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce)
    begin
      wb_ack_o <= wb_acc;
      if (wb_acc && !wb_we_i)
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {31'h00000000, en_r};
          `REG_STATUS: wb_dat_o <= {24'h000000, (cnt_r == 2'd2),
                                    (state_r != S_IDLE), half_r, enl_r,
                                    fl_r, inv_r};
          `REG_CURSOR: wb_dat_o <= {17'h00000, cur_y_r, cur_x_r};
          `REG_DISCARD: wb_dat_o <= {16'h0000, disc_r};
          default: wb_dat_o <= 32'h00000000;
        endcase
    end
  end

endmodule // terminal_draw_command_parser

/* testbench/term_host_model.sv */
`timescale 1ns/1ps
module term_host_model (
  input wire mclk,
  input wire reset,
  input wire rx_ready,
  input wire slow,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic [7:0] q[$];
  task put(input logic [7:0] b);
    q.push_back(b);
  endtask
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // idle data toggles so a stale byte never looks like a fresh one
  always @(posedge mclk)
    if (reset)
      rx_valid <= 1'b0;
    else if (!rx_valid || rx_ready)
    begin
      if (q.size() > 0 && !slow)
      begin
        rx_data <= q.pop_front();
        rx_valid <= 1'b1;
      end
      else
      begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
endmodule // term_host_model

/* testbench/term_parser_sva.sv */
`timescale 1ns/1ps
module term_parser_sva (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rx_ready,
  input wire out_valid,
  input wire out_ready,
  input wire [2:0] out_op,
  input wire [7:0] out_x,
  input wire [6:0] out_y,
  input wire [7:0] out_arg,
  input wire [2:0] out_enlarge
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("ack late");
  chk_ce_freeze: assert property (
    !ce |-> !rx_ready && !out_valid) else $error("active while ce low");
  chk_word_holds: assert property (
    out_valid && !out_ready ##1 ce |-> out_valid &&
    $stable({out_op, out_x, out_y, out_arg})) else $error("word changed");
  chk_enl_range: assert property (
    out_valid |-> out_enlarge <= 3'd5) else $error("enlargement range");
  chk_circle_radius: assert property (
    out_valid && out_op == 3'h4 |-> out_arg inside {[8'd1:8'd63]})
    else $error("radius range");
  chk_line_arg: assert property (
    out_valid && (out_op == 3'h2 || out_op == 3'h3) |-> out_arg == 8'h00)
    else $error("line arg not zero");
  chk_op_legal: assert property (
    out_valid |-> out_op inside {[3'h1:3'h4]}) else $error("bad op");
  cover property (out_valid && out_ready && out_op == 3'h4);
  cover property (out_valid && out_ready && out_op == 3'h3);
  cover property (out_valid && !out_ready ##1 out_valid);
endmodule // term_parser_sva
bind terminal_draw_command_parser term_parser_sva u_chk (.mclk(mclk),
  .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rx_ready(rx_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_op(out_op), .out_x(out_x), .out_y(out_y),
  .out_arg(out_arg), .out_enlarge(out_enlarge));

/* testbench/terminal_draw_command_parser_tb.sv */
`timescale 1ns/1ps
module terminal_draw_command_parser_tb;
  logic mclk, reset, ce, screen_shown, out_ready, slow, hold;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_ready, rx_valid;
  logic out_valid, out_inverse, out_flash, out_half, inv, fl, half;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic [7:0] rx_data, out_x, out_arg;
  logic [6:0] out_y;
  logic [2:0] out_op, out_enlarge;
  logic [31:0] exp_q[$];
  logic [7:0] codes[7] = '{8'h22, 8'h24, 8'h23, 8'h22, 8'h25, 8'h24, 8'h21};
  int wfa[6] = '{1, 1, 2, 2, 3, 4};
  int hfa[6] = '{1, 2, 1, 2, 3, 4};
  int enl, cx, cy, n_errors, n_tests;
  terminal_draw_command_parser uut (.mclk(mclk), .reset(reset), .ce(ce),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .screen_shown(screen_shown), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .out_valid(out_valid), .out_ready(out_ready), .out_op(out_op),
    .out_x(out_x), .out_y(out_y), .out_arg(out_arg),
    .out_inverse(out_inverse), .out_flash(out_flash),
    .out_enlarge(out_enlarge), .out_half(out_half));
  term_host_model host (.mclk(mclk), .reset(reset), .rx_ready(rx_ready),
    .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task err(input string m);
    n_errors++;
    $display("unexpected %0t %s", $time, m);
  endtask
  task final_report;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s = 4'h1);
    int i;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    i = 0;
    // ack and read data are taken at the same rising edge
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (i >= 50)
    begin
      err("bus timeout");
      final_report;
    end
  endtask
  task chk_rd(input logic [3:0] a, input logic [31:0] m, e);
    wb(a, 1'b0, 32'h0);
    n_tests++;
    if ((rd & m) !== e)
      err("register read");
  endtask
  task esc(input logic [7:0] c);
    host.put(8'h1b);
    host.put(c);
  endtask
  task bcd(input int v);
    host.put(8'(8'h30 + v / 100));
    host.put(8'(8'h30 + v / 10 % 10));
    host.put(8'(8'h30 + v % 10));
  endtask
  task note(input int op, x, y, a);
    exp_q.push_back({3'(op), 8'(x), 7'(y), 8'(a), inv, fl, 3'(enl), half});
  endtask
  task circle(input int x, y, r);
    esc(8'h38);
    bcd(x);
    bcd(y);
    bcd(r);
    if (r >= 1 && r <= 63)
      note(4, x, y, r);
  endtask
  task str(input int n);
    int x, y, w, h;
    w = 8 * wfa[enl];
    h = (half ? 8 : 16) * hfa[enl];
    x = cx;
    y = cy;
    esc(8'h34);
    host.put(8'h30);
    host.put(8'(8'h30 + n));
    for (int i = 0; i < n; i++)
    begin
      if (x + w > 256)
      begin
        x = 0;
        y = (y + h) % 128;
      end
      host.put(8'(8'h41 + i));
      note(1, x, y, 8'h41 + i);
      x += w;
    end
  endtask
  task drain;
    int i;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge mclk);
      if (host.q.size() == 0 && exp_q.size() == 0 && !rx_valid)
        break;
    end
    if (i >= 4000)
    begin
      err("stream stalled");
      final_report;
    end
  endtask
  always @(posedge mclk)
    if (!reset && out_valid && out_ready)
    begin
      n_tests++;
      if (exp_q.size() == 0)
        err("extra word");
      else if ({out_op, out_x, out_y, out_arg, out_inverse, out_flash,
               out_enlarge, out_half} !== exp_q.pop_front())
        err("word mismatch");
    end
  always @(posedge mclk)
  begin
    seed <= lfsr(seed);
    out_ready <= !hold && (seed[3] | seed[9]);
    slow <= seed[5] & seed[12];
  end
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    {reset, ce, screen_shown, out_ready, slow, hold} = 6'b110000;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {inv, fl, half, enl, n_errors, n_tests} = '0;
    wb_sel_i = 4'h1;
    seed = 32'h95a3f562;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    chk_rd(4'h0, 32'h1, 32'h1);
    // a write without byte lane 0 must leave the enable alone
    wb(4'h0, 1'b1, 32'h0, 4'h2);
    chk_rd(4'h0, 32'h1, 32'h1);
    chk_rd(4'h4, 32'hff, 32'h0);
    chk_rd(4'h2, 32'hffffffff, 32'h0);
    esc(8'h2b);
    bcd(200);
    bcd(100);
    cx = 200;
    cy = 100;
    foreach (codes[i])
    begin
      @(posedge mclk);
      esc(codes[i]);
      case (codes[i])
        8'h21: {inv, fl} = 2'b00;
        8'h22: inv = 1'b1;
        8'h23: inv = 1'b0;
        8'h24: fl = 1'b1;
        default: fl = 1'b0;
      endcase
      circle(seed[7:0], seed[14:8], 1 + seed[20:15] % 63);
    end
    for (int e = 0; e < 6; e++)
    begin
      esc(8'h2a);
      host.put(8'(8'h30 + e));
      enl = e;
      str(3);
    end
    esc(8'h29);
    host.put(8'h31);
    half = 1'b1;
    str(2);
    esc(8'h2a);
    host.put(8'h36);
    circle(10, 10, 64);
    circle(10, 10, 0);
    drain;
    chk_rd(4'hc, 32'hffff, 32'h3);
    wb(4'hc, 1'b1, 32'h0);
    chk_rd(4'hc, 32'hffff, 32'h0);
    esc(8'h37);
    host.put(8'h30);
    host.put(8'h32);
    bcd(0);
    bcd(0);
    bcd(255);
    bcd(127);
    bcd(9);
    bcd(64);
    note(2, 0, 0, 0);
    note(3, 255, 127, 0);
    note(3, 9, 64, 0);
    drain;
    screen_shown <= 1'b1;
    @(posedge mclk);
    screen_shown <= 1'b0;
    {inv, fl, half, enl} = '0;
    circle(5, 6, 63);
    drain;
    hold <= 1'b1;
    repeat (3) circle(1, 2, 3);
    repeat (80) @(posedge mclk);
    chk_rd(4'h4, 32'h80, 32'h80);
    hold <= 1'b0;
    drain;
    wb(4'h0, 1'b1, 32'h0);
    circle(7, 8, 9);
    repeat (40) @(posedge mclk);
    n_tests++;
    if (exp_q.size() !== 1)
      err("parser ran while disabled");
    wb(4'h0, 1'b1, 32'h1);
    drain;
    // leave a circle with only its x field sent, then abort it and change screen together
    esc(8'h22);
    esc(8'h38);
    bcd(1);
    drain;
    chk_rd(4'h4, 32'h41, 32'h41);
    wb(4'h0, 1'b1, 32'h7);
    chk_rd(4'h4, 32'h7f, 32'h0);
    circle(2, 3, 4);
    drain;
    circle(1, 1, 1);
    repeat (6) @(posedge mclk);
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    drain;
    final_report;
  end
endmodule // terminal_draw_command_parser_tb
